//--- verilog/ees_slave.sv
// Purpose: slave logic of a 64K x 8 serial memory on a two-wire bus
// Assumes: master drives the clock; i_rstn is the power-on reset
// Notes:   page buffer of 128 bytes committed during the busy period
//
// How it works
// - start is data falling while clock high; nothing happens before one
// - stop is data rising while clock high; launches write or returns to idle
// - data change with clock high is always taken as start or stop
// - bits sampled on clock rise, driven on clock fall, open-drain only
// - address byte: 1010, three strap bits high first, then direction bit
// - acknowledge address, both offset bytes and written data on ninth clock
// - read: eight bits out, release on ninth, go on only if master acks
// - byte write: address, two offset bytes, data, stop starts the write
// - while busy writing, the address byte is never acknowledged
// - offset is 9-bit page index above a 7-bit in-page offset
// - offset increments per data byte; only the low seven bits wrap
// - up to 128 bytes committed in one cycle started by the stop
// - write-protect high inhibits every write; low leaves all unchanged
// - protect sampled on the fall before first data; if high, nack, reject
// - every byte reads FFh before first written
// - idle counter points past the last byte touched, wrapping at the end
// - read address acknowledged, then byte at the counter is sent
// - dummy write of offset, repeated start and read loads the counter
// - sequential read continues while acked; counter wraps to zero
// - reset holds everything idle; release enters standby
// - zero is pulled low, one is released; master owns clock and conditions
`timescale 1ns/1ps
module ees_slave
    import ees_pkg::*;
#(
    parameter int unsigned WR_CYCLES = WR_CYCLES_DEF
) (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    // two-wire bus
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda,
    output logic      o_sda_oe,
    // straps and protection
    input  wire logic i_strap_select_bit0,
    input  wire logic i_strap_select_bit1,
    input  wire logic i_strap_select_bit2,
    input  wire logic i_write_protect,
    // status
    output logic      o_busy
);

    // ==========================================================
    // state
    typedef struct packed {
        ees_state_t          st;
        logic [3:0]          bit_cnt;
        logic [7:0]          sh;
        logic [7:0]          tx;
        logic [ADDR_W-1:0]   addr;
        logic                rd_dir;
        logic                ack;
        logic                mack;
        logic                wp;
        logic                oe;
        logic                sda_o;
        logic                busy;
        logic [TMR_W-1:0]    tmr;
        logic [7:0]          cidx;
        logic [PAGE_LEN-1:0] vld;
        logic [PAGE_W-1:0]   page;
        logic                pb_we;
        logic [OFS_W-1:0]    pb_wa;
        logic [7:0]          wdat;
        logic                mem_we;
        logic [ADDR_W-1:0]   mem_wa;
    } ees_core_t;

    ees_core_t s_q;
    ees_core_t s_d;

    ees_evt_t          evt;
    logic [7:0]        mem_rdata;
    logic [7:0]        pb_rdata;
    logic [7:0]        byte_in;
    logic [2:0]        straps;
    logic              launch;

    // ==========================================================
    // line events
    ees_line_edges u_edges (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_scl     (i_scl),
        .i_sda     (i_sda),
        .o_evt     (evt)
    );

    // ==========================================================
    // array and page buffer
    ees_mem #(.AW(ADDR_W), .DW(DATA_W), .INIT(ERASED)) u_array (
        .i_sys_clk (i_sys_clk),
        .i_we      (s_q.mem_we),
        .i_waddr   (s_q.mem_wa),
        .i_wdata   (pb_rdata),
        .i_raddr   (s_q.addr),
        .o_rdata   (mem_rdata)
    );

    ees_mem #(.AW(OFS_W), .DW(DATA_W), .INIT(ERASED)) u_page (
        .i_sys_clk (i_sys_clk),
        .i_we      (s_q.pb_we),
        .i_waddr   (s_q.pb_wa),
        .i_wdata   (s_q.wdat),
        .i_raddr   (s_q.cidx[OFS_W-1:0]),
        .o_rdata   (pb_rdata)
    );

    // ==========================================================
    // next state
    assign straps  = {i_strap_select_bit2, i_strap_select_bit1, i_strap_select_bit0};
    assign byte_in = {s_q.sh[6:0], i_sda};
    assign launch  = (s_q.st == S_WDATA) && (|s_q.vld) && !s_q.busy;

    always_comb begin
        s_d        = s_q;
        s_d.pb_we  = 1'b0;
        s_d.mem_we = 1'b0;
        s_d.sda_o  = 1'b0;
        // commit engine and write timer
        if (s_q.busy) begin
            s_d.tmr = s_q.tmr + 1'b1;
            if (!s_q.cidx[7]) begin
                s_d.mem_we = s_q.vld[s_q.cidx[OFS_W-1:0]];
                s_d.mem_wa = {s_q.page, s_q.cidx[OFS_W-1:0]};
                s_d.cidx   = s_q.cidx + 8'h01;
            end
            if (s_q.tmr == TMR_W'(WR_CYCLES - 1)) begin
                s_d.busy = 1'b0;
                s_d.vld  = '0;
            end
        end
        // bus protocol
        if (evt.start) begin
            s_d.st      = S_DEVADDR;
            s_d.bit_cnt = 4'h0;
            s_d.oe      = 1'b0;
            if (!s_q.busy) begin
                s_d.vld = '0;
            end
        end else if (evt.stop) begin
            s_d.oe = 1'b0;
            s_d.st = S_IDLE;
            if (launch) begin
                s_d.busy = 1'b1;
                s_d.tmr  = '0;
                s_d.cidx = 8'h00;
            end
        end else if (s_q.st != S_IDLE && s_q.st != S_IGNORE) begin
            if (evt.rise) begin
                if (s_q.bit_cnt < 4'(BIT_ACK)) begin
                    s_d.sh      = byte_in;
                    s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    if (s_q.bit_cnt == 4'(BIT_ACK - 1)) begin
                        s_d.ack = 1'b1;
                        case (s_q.st)
                            S_DEVADDR: begin
                                s_d.rd_dir = byte_in[0];
                                if (byte_in[7:4] != DEV_PREFIX || byte_in[3:1] != straps
                                    || s_q.busy) begin
                                    s_d.st  = S_IGNORE;
                                    s_d.ack = 1'b0;
                                end
                            end
                            S_ADDRHI: begin
                                s_d.addr[15:8] = byte_in;
                            end
                            S_ADDRLO: begin
                                s_d.addr[7:0] = byte_in;
                            end
                            S_WDATA: begin
                                if (s_q.wp) begin
                                    s_d.st  = S_IGNORE;
                                    s_d.ack = 1'b0;
                                end else begin
                                    s_d.pb_we = 1'b1;
                                    s_d.pb_wa = s_q.addr[OFS_W-1:0];
                                    s_d.wdat  = byte_in;
                                    s_d.page  = s_q.addr[ADDR_W-1:OFS_W];
                                    s_d.vld[s_q.addr[OFS_W-1:0]] = 1'b1;
                                    s_d.addr[OFS_W-1:0] = s_q.addr[OFS_W-1:0] + 7'h01;
                                end
                            end
                            default: begin
                                s_d.ack = 1'b0;
                            end
                        endcase
                    end
                end else begin
                    s_d.bit_cnt = 4'(BIT_HOST);
                    s_d.mack    = !i_sda;
                end
            end
            if (evt.fall) begin
                if (s_q.bit_cnt == 4'(BIT_ACK)) begin
                    s_d.oe = (s_q.st == S_RDATA) ? 1'b0 : s_q.ack;
                end else if (s_q.bit_cnt == 4'(BIT_HOST)) begin
                    s_d.oe      = 1'b0;
                    s_d.bit_cnt = 4'h0;
                    case (s_q.st)
                        S_DEVADDR: begin
                            if (s_q.rd_dir) begin
                                s_d.st   = S_RDATA;
                                s_d.tx   = {mem_rdata[6:0], 1'b0};
                                s_d.oe   = !mem_rdata[7];
                                s_d.addr = s_q.addr + 16'h0001;
                            end else begin
                                s_d.st = S_ADDRHI;
                            end
                        end
                        S_ADDRHI: begin
                            s_d.st = S_ADDRLO;
                        end
                        S_ADDRLO: begin
                            s_d.st = S_WDATA;
                            s_d.wp = i_write_protect;
                        end
                        S_RDATA: begin
                            if (s_q.mack) begin
                                s_d.tx   = {mem_rdata[6:0], 1'b0};
                                s_d.oe   = !mem_rdata[7];
                                s_d.addr = s_q.addr + 16'h0001;
                            end else begin
                                s_d.st = S_IGNORE;
                            end
                        end
                        default: begin
                            s_d.st = s_q.st;
                        end
                    endcase
                end else if (s_q.st == S_RDATA) begin
                    s_d.oe = !s_q.tx[7];
                    s_d.tx = {s_q.tx[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            s_q      <= '0;
            s_q.st   <= S_IDLE;
            s_q.addr <= ADDR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign o_sda    = s_q.sda_o;
    assign o_sda_oe = s_q.oe;
    assign o_busy   = s_q.busy;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    sequence seq_addr_byte_done;
        evt.rise && !evt.start && !evt.stop && s_q.st == S_DEVADDR
            && s_q.bit_cnt == 4'(BIT_ACK - 1);
    endsequence

    sequence seq_ack_slot;
        evt.fall && !evt.start && !evt.stop && s_q.bit_cnt == 4'(BIT_ACK);
    endsequence

    chk_idle_released: assert property (
        (s_q.st == S_IDLE || s_q.st == S_IGNORE) && !$past(s_q.oe) |-> !o_sda_oe)
        else $error("line driven while idle or ignoring");

    chk_stop_launch: assert property (
        evt.stop && launch |=> o_busy && s_q.st == S_IDLE && s_q.tmr == '0)
        else $error("stop after data did not start write");

    chk_stop_no_launch: assert property (
        evt.stop && !launch && !o_busy |=> !o_busy && s_q.st == S_IDLE)
        else $error("stop without data started a write");

    chk_drive_on_fall: assert property (
        $changed(o_sda_oe) && !$past(evt.start) && !$past(evt.stop) |-> $past(evt.fall))
        else $error("data line changed away from clock fall");

    chk_busy_nack: assert property (
        seq_addr_byte_done and o_busy |=> s_q.st == S_IGNORE ##1 !o_sda_oe)
        else $error("address acknowledged while busy");

    chk_addr_match: assert property (
        seq_addr_byte_done and !o_busy and (byte_in[7:4] == DEV_PREFIX)
            and (byte_in[3:1] == straps) |=> s_q.ack && s_q.st == S_DEVADDR)
        else $error("matching address not prepared for acknowledge");

    chk_ack_drive: assert property (
        seq_ack_slot and (s_q.st != S_RDATA) and s_q.ack |=> o_sda_oe)
        else $error("acknowledge not driven on ninth clock");

    chk_read_release: assert property (
        seq_ack_slot and (s_q.st == S_RDATA) |=> !o_sda_oe)
        else $error("line not released for master acknowledge");

    chk_page_wrap: assert property (
        s_q.pb_we |-> s_q.addr[ADDR_W-1:OFS_W] == s_q.page
            && s_q.addr[OFS_W-1:0] == s_q.pb_wa + 7'h01)
        else $error("in-page offset did not advance within page");

    chk_protect_reject: assert property (
        evt.rise && !evt.stop && !evt.start && s_q.st == S_WDATA && s_q.wp
            && s_q.bit_cnt == 4'(BIT_ACK - 1) |=> s_q.st == S_IGNORE && !s_q.pb_we
            && $stable(s_q.vld))
        else $error("protected write was accepted");

    chk_seq_wrap: assert property (
        evt.fall && !evt.start && !evt.stop && s_q.st == S_RDATA && s_q.mack
            && s_q.bit_cnt == 4'(BIT_HOST) && s_q.addr == 16'hFFFF |=> s_q.addr == ADDR_RST)
        else $error("read counter did not wrap to zero");

    chk_busy_len: assert property (
        $fell(o_busy) |-> $past(s_q.tmr) == TMR_W'(WR_CYCLES - 1))
        else $error("busy ended before write duration");

endmodule // ees_slave

//--- verilog/ees_pkg.sv
// Purpose: shared constants and types of the two-wire serial memory slave
// Assumes: one 125 MHz system clock, bus pins already synchronous to it
// Notes:   write-cycle length is a top-level parameter defaulting to WR_CYCLES_DEF
package ees_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned WR_TIME_NS    = 5000000;
    localparam int unsigned WR_CYCLES_DEF = WR_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned TMR_W         = 24;

    // ==========================================================
    // array and page geometry
    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned PAGE_W   = 9;
    localparam int unsigned OFS_W    = 7;
    localparam int unsigned PAGE_LEN = 128;
    localparam int unsigned DATA_W   = 8;

    // ==========================================================
    // field positions and reset values
    localparam logic [3:0]        DEV_PREFIX = 4'hA;
    localparam int unsigned       BIT_ACK    = 8;
    localparam int unsigned       BIT_HOST   = 9;
    localparam logic [7:0]        ERASED     = 8'hFF;
    localparam logic [ADDR_W-1:0] ADDR_RST   = 16'h0000;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        S_IDLE    = 3'b000,
        S_DEVADDR = 3'b001,
        S_ADDRHI  = 3'b010,
        S_ADDRLO  = 3'b011,
        S_WDATA   = 3'b100,
        S_RDATA   = 3'b101,
        S_IGNORE  = 3'b110
    } ees_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } ees_line_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } ees_evt_t;

endpackage

//--- verilog/ees_line_edges.sv
// Purpose: clock edges and start/stop detection on the two bus lines
// Assumes: lines sampled synchronously to i_sys_clk
// Notes:   events are single-cycle pulses, valid in the cycle of the change
`timescale 1ns/1ps
module ees_line_edges
    import ees_pkg::*;
(
    // clock and reset
    input  wire logic     i_sys_clk,
    input  wire logic     i_rstn,
    // bus lines
    input  wire logic     i_scl,
    input  wire logic     i_sda,
    // events
    output ees_evt_t      o_evt
);

    // ==========================================================
    // state
    ees_line_t s_q;
    ees_line_t s_d;

    always_comb begin
        s_d     = '{scl: i_scl, sda: i_sda};
        o_evt.rise  = !s_q.scl && i_scl;
        o_evt.fall  = s_q.scl && !i_scl;
        o_evt.start = s_q.scl && i_scl && s_q.sda && !i_sda;
        o_evt.stop  = s_q.scl && i_scl && !s_q.sda && i_sda;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            s_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

endmodule // ees_line_edges

//--- verilog/ees_mem.sv
// Purpose: simple dual-port storage with registered read data
// Assumes: one write and one read per cycle
// Notes:   contents start at INIT, as an unwritten part delivers
`timescale 1ns/1ps
module ees_mem #(
    parameter int unsigned AW        = 16,
    parameter int unsigned DW        = 8,
    parameter logic [DW-1:0] INIT    = '1
) (
    // clock
    input  wire logic          i_sys_clk,
    // write port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    // read port
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);

    // ==========================================================
    // storage
    logic [DW-1:0] mem [0:(1<<AW)-1];

    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            mem[i] = INIT;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end

endmodule // ees_mem

//--- dv/ees_bus_master.sv
// Purpose: two-wire bus master model that drives clock and data
// Assumes: i_sda is the wire level, pulled up while released
// Notes:   bench calls the tasks; HALF sets each clock phase in cycles
`timescale 1ns/1ps
module ees_bus_master #(
    parameter int HALF = 4
) (
    // clock
    input  wire logic i_sys_clk,
    // bus
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    // ==========================================================
    // bus phases
    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic clk_low();
        o_scl = 1'b0;
        tick(1);
    endtask
    task automatic start();
        o_sda_oe = 1'b0;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda_oe = 1'b1;
        tick(HALF);
        clk_low();
    endtask
    task automatic stop();
        o_sda_oe = 1'b1;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda_oe = 1'b0;
        tick(HALF);
    endtask
    task automatic bit_io(input logic b, output logic s);
        o_sda_oe = !b;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        s = i_sda;
        clk_low();
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic get_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!mack, s);
    endtask
endmodule // ees_bus_master

//--- dv/testbench.sv
// Purpose: self-checking bench of the serial memory slave
// Assumes: master model owns the clock line; wire is wired-AND
// Notes:   write cycle shortened to WRC cycles
`timescale 1ns/1ps
module testbench
    import ees_pkg::*;
;
    typedef struct packed {
        logic       st;
        logic [2:0] strap;
        logic [7:0] adr;
        logic       ack;
    } ees_row_t;
    localparam int unsigned WRC   = 500;
    localparam int unsigned WD    = 80000;
    localparam logic [2:0]  STRAP = 3'b101;
    localparam ees_row_t    ROWS [8] = '{
        '{1'b1, 3'b101, 8'hAA, 1'b1}, '{1'b1, 3'b010, 8'hA4, 1'b1},
        '{1'b1, 3'b010, 8'hA6, 1'b0}, '{1'b1, 3'b100, 8'hA0, 1'b0},
        '{1'b1, 3'b000, 8'h20, 1'b0}, '{1'b1, 3'b111, 8'hBE, 1'b0},
        '{1'b1, 3'b111, 8'hAE, 1'b1}, '{1'b0, 3'b111, 8'hAE, 1'b0}};
    logic       i_sys_clk, i_rstn, i_write_protect, o_sda, o_sda_oe, o_busy;
    logic       m_scl, m_oe, sda_w, ack;
    logic [2:0] strap;
    int         bad_count, n_tests, busy_run, last_busy;
    logic [7:0] exp_mem [int unsigned];

    // ==========================================================
    // design, master and wire
    assign sda_w = (o_sda_oe ? o_sda : 1'b1) & !m_oe;
    ees_slave #(.WR_CYCLES(WRC)) ees_slave_i (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_scl(m_scl), .i_sda(sda_w),
        .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_strap_select_bit0(strap[0]),
        .i_strap_select_bit1(strap[1]), .i_strap_select_bit2(strap[2]),
        .i_write_protect(i_write_protect), .o_busy(o_busy));
    ees_bus_master ees_bus_master_i (
        .i_sys_clk(i_sys_clk), .i_sda(sda_w), .o_scl(m_scl), .o_sda_oe(m_oe));
    initial i_sys_clk = 1'b0;
    always #4 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        if (o_busy === 1'b1) begin
            busy_run++;
        end else if (busy_run != 0) begin
            last_busy = busy_run;
            busy_run  = 0;
        end
    end

    // ==========================================================
    // compare and report
    task automatic chk_bit(input logic a, input logic e, input string m);
        n_tests++;
        if (a !== e) begin
            bad_count++;
            $display("ERROR %0t %s got %b exp %b", $time, m, a, e);
        end
    endtask
    task automatic chk_byte(input logic [7:0] a, input logic [7:0] e, input string m);
        n_tests++;
        if (a !== e) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, m, a, e);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        return exp_mem.exists(a) ? exp_mem[a] : ERASED;
    endfunction

    // ==========================================================
    // transfers
    task automatic send_ofs(input logic [15:0] a);
        ees_bus_master_i.start();
        ees_bus_master_i.put_byte({DEV_PREFIX, strap, 1'b0}, ack);
        chk_bit(ack, 1'b1, "dev ack");
        ees_bus_master_i.put_byte(a[15:8], ack);
        chk_bit(ack, 1'b1, "hi ack");
        ees_bus_master_i.put_byte(a[7:0], ack);
        chk_bit(ack, 1'b1, "lo ack");
    endtask
    task automatic write_seq(input logic [15:0] a, input int n, input logic [7:0] s,
                             input logic ok);
        logic [15:0] p;
        send_ofs(a);
        for (int i = 0; i < n; i++) begin
            p = {a[15:7], a[6:0] + 7'(i)};
            ees_bus_master_i.put_byte(s + 8'(i), ack);
            chk_bit(ack, ok, "data ack");
            if (ok) begin
                exp_mem[p] = s + 8'(i);
            end
        end
        ees_bus_master_i.stop();
        ees_bus_master_i.tick(3);
        chk_bit(o_busy, ok, "busy");
    endtask
    task automatic wait_write();
        last_busy = 0;
        for (int k = 0; k < 2; k++) begin
            ees_bus_master_i.start();
            ees_bus_master_i.put_byte({DEV_PREFIX, strap, k[0]}, ack);
            chk_bit(ack, 1'b0, "poll ack");
            ees_bus_master_i.stop();
        end
        for (int k = 0; k < 1000 && o_busy !== 1'b0; k++) begin
            ees_bus_master_i.tick(1);
        end
        ees_bus_master_i.tick(2);
        chk_bit(last_busy inside {WRC - 1, WRC}, 1'b1, "busy span");
    endtask
    task automatic read_seq(input logic [15:0] a, input logic sel, input int n);
        logic [7:0] d;
        if (sel) begin
            send_ofs(a);
        end
        ees_bus_master_i.start();
        ees_bus_master_i.put_byte({DEV_PREFIX, strap, 1'b1}, ack);
        chk_bit(ack, 1'b1, "read ack");
        for (int i = 0; i < n; i++) begin
            ees_bus_master_i.get_byte(i != n - 1, d);
            chk_byte(d, exp_rd(a + 16'(i)), "read data");
        end
        ees_bus_master_i.stop();
    endtask

    // ==========================================================
    // main sequence
    initial begin
        i_rstn          = 1'b0;
        i_write_protect = 1'b0;
        strap           = STRAP;
        bad_count       = 0;
        n_tests         = 0;
        busy_run        = 0;
        last_busy       = 0;
        repeat (3) @(posedge i_sys_clk);
        #1;
        chk_bit(o_busy, 1'b0, "rst busy");
        chk_bit(o_sda_oe, 1'b0, "rst oe");
        chk_bit(o_sda, 1'b0, "rst sda level");
        i_rstn = 1'b1;
        ees_bus_master_i.tick(3);
        foreach (ROWS[r]) begin
            strap = ROWS[r].strap;
            ees_bus_master_i.tick(1);
            if (ROWS[r].st) begin
                ees_bus_master_i.start();
            end else begin
                ees_bus_master_i.clk_low();
            end
            ees_bus_master_i.put_byte(ROWS[r].adr, ack);
            chk_bit(ack, ROWS[r].ack, "row ack");
            ees_bus_master_i.stop();
            ees_bus_master_i.tick(3);
            chk_bit(o_busy, 1'b0, "row busy");
        end
        strap = STRAP;
        read_seq(16'hFFFE, 1'b1, 3);
        write_seq(16'h01FE, 130, 8'h11, 1'b1);
        wait_write();
        read_seq(16'h0180, 1'b1, 128);
        strap = 3'b010;
        write_seq(16'hFFFF, 1, 8'h3C, 1'b1);
        wait_write();
        write_seq(16'h0000, 2, 8'hC3, 1'b1);
        wait_write();
        read_seq(16'hFFFE, 1'b1, 3);
        read_seq(16'h0001, 1'b0, 1);
        i_write_protect = 1'b1;
        write_seq(16'h0001, 1, 8'h55, 1'b0);
        i_write_protect = 1'b0;
        read_seq(16'h0001, 1'b1, 1);
        write_seq(16'h0100, 1, 8'h77, 1'b1);
        i_rstn = 1'b0;
        ees_bus_master_i.tick(3);
        chk_bit(o_busy, 1'b0, "mid rst busy");
        chk_bit(o_sda_oe, 1'b0, "mid rst oe");
        chk_bit(o_sda, 1'b0, "mid rst sda level");
        i_rstn = 1'b1;
        ees_bus_master_i.tick(3);
        read_seq(16'h0000, 1'b0, 1);
        give_verdict();
    end

    // ==========================================================
    // watchdog, about three times the expected run
    initial begin
        #(8 * WD);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        give_verdict();
    end
endmodule // testbench
